// >>> sim/sac_src_model.sv
/* sac_src_model: far-end audio source sending subframe auxiliary bits.
 * Assumes the bench calls send_block; the link clock stands still between calls. */
module sac_src_model (
    output logic link_clk_o,
    output logic link_left_o,
    output logic link_start_o,
    output logic link_cs_o,
    output logic link_ud_o,
    output logic link_vb_o,
    output logic link_pb_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {link_clk_o, link_left_o, link_start_o, link_cs_o, link_ud_o, link_vb_o, link_pb_o} = '0;
    // group g of frame f carries bit g of f; data change on the falling edge
    task automatic send_block(input int n, input bit inv);
        logic [7:0] f;
        for (int k = 0; k < 2 * n; k++) begin
            f = 8'(k / 2);
            link_clk_o = 1'b0;
            link_left_o = ~k[0];
            link_start_o = (k == 0);
            link_cs_o = f[k[0]] ^ inv;
            link_ud_o = f[2 + k[0]] ^ inv;
            link_vb_o = f[4 + k[0]] ^ inv;
            link_pb_o = f[6 + k[0]] ^ inv;
            #62.5;
            link_clk_o = 1'b1;
            #62.5;
        end
        // released lines show the inverse of the last value
        {link_cs_o, link_ud_o, link_vb_o, link_pb_o} = ~{link_cs_o, link_ud_o, link_vb_o, link_pb_o};
    endtask : send_block
endmodule : sac_src_model

// >>> sim/sac_top_asserts.sv
/* sac_top_asserts: port checks for sac_top.
 * Assumes a single clock domain, clk_sys_i with srst_i. */
module sac_top_chk
    import sac_pkg::*;
(
    input wire logic                       clk_sys_i,
    input wire logic                       srst_i,
    input wire logic [15:0]                reg_addr_i,
    input wire logic [15:0]                reg_wdata_i,
    input wire logic                       reg_wr_i,
    input wire logic                       reg_rd_i,
    input wire logic [15:0]                reg_rdata_o,
    input wire logic                       link_left_i,
    input wire logic [SAC_AUDIO_WIDTH-1:0] tx_audio_i,
    input wire logic                       tx_power_on_i,
    input wire logic [SAC_AUDIO_WIDTH-1:0] tx_audio_o,
    input wire logic                       tx_output_enable_o,
    input wire logic                       tx_stream_run_o,
    input wire logic                       aux_block_ready_flag_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // ****
    // ready flag and transmitter control
    // ****
    ready_read_a: assert property (reg_rd_i && reg_addr_i == SAC_ADDR_AUX_BLOCK_READY
        |=> reg_rdata_o == {15'h0000, $past(aux_block_ready_flag_o)}) else $error("bad ready read");
    ready_hold_a: assert property (aux_block_ready_flag_o |=> aux_block_ready_flag_o)
        else $error("ready flag dropped");
    ready_clear_a: assert property ($fell(srst_i) |-> !aux_block_ready_flag_o)
        else $error("ready set after reset");
    tx_write_a: assert property (reg_wr_i && reg_addr_i == SAC_ADDR_TX_OUTPUT_CONTROL
        |=> tx_output_enable_o == $past(reg_wdata_i[0])) else $error("enable not written");
    tx_hold_a: assert property (!(reg_wr_i && reg_addr_i == SAC_ADDR_TX_OUTPUT_CONTROL)
        |=> $stable(tx_output_enable_o)) else $error("enable moved alone");
    tx_read_a: assert property (reg_rd_i && reg_addr_i == SAC_ADDR_TX_OUTPUT_CONTROL
        |=> reg_rdata_o == {15'h0000, $past(tx_output_enable_o)}) else $error("bad enable read");
    tx_zero_a: assert property (!tx_output_enable_o |=> tx_audio_o == '0)
        else $error("disabled output not zero");
    tx_pass_a: assert property (tx_output_enable_o |=> tx_audio_o == $past(tx_audio_i))
        else $error("enabled output wrong");
    power_keep_a: assert property (1'b1 |=> tx_stream_run_o == $past(tx_power_on_i))
        else $error("stream run not power");
    cover property ($rose(aux_block_ready_flag_o));
    cover property (reg_wr_i && reg_addr_i == SAC_ADDR_TX_OUTPUT_CONTROL && reg_wdata_i[0]);
    cover property (reg_rd_i && reg_addr_i == SAC_ADDR_RX_PARITY_RIGHT + 16'h000b);
endmodule : sac_top_chk

bind sac_top sac_top_chk i_chk (.clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .link_left_i, .tx_audio_i, .tx_power_on_i, .tx_audio_o,
    .tx_output_enable_o, .tx_stream_run_o, .aux_block_ready_flag_o);

// >>> sim/sac_top_test.sv
/* sac_top_test: self-checking bench for sac_top.
 * Assumes sac_src_model on the link side and the checker bound in. */
module sac_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    import sac_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        pwr = 1'b1;
    logic [23:0] ain = 24'habcdef;
    logic [23:0] aout;
    logic [15:0] rdata;
    logic        lclk, lleft, lstart, lcs, lud, lvb, lpb, bready, ovr, tx_output_enable, run, rdy;
    int          err_total = 0;
    int          check_count = 0;
    always #2 clk = ~clk;
    sac_top i_dut (.clk_sys_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .link_clk_i(lclk),
        .link_left_i(lleft), .link_blk_start_i(lstart), .link_cs_i(lcs), .link_ud_i(lud),
        .link_vb_i(lvb), .link_pb_i(lpb), .link_buf_ready_o(bready), .link_overrun_o(ovr),
        .tx_audio_i(ain), .tx_power_on_i(pwr), .tx_audio_o(aout), .tx_output_enable_o(tx_output_enable),
        .tx_stream_run_o(run), .aux_block_ready_flag_o(rdy));
    sac_src_model i_src (.link_clk_o(lclk), .link_left_o(lleft), .link_start_o(lstart),
        .link_cs_o(lcs), .link_ud_o(lud), .link_vb_o(lvb), .link_pb_o(lpb));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, input logic [15:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp, what);
    endtask : rd_reg
    // register i of group g: bit j holds bit g of frame 16i+j
    function automatic logic [15:0] exp_reg(input int g, input int i, input bit inv);
        logic [15:0] e;
        logic [7:0]  f;
        for (int j = 0; j < 16; j++) begin
            f = 8'(16 * i + j);
            e[j] = f[g] ^ inv;
        end
        return e;
    endfunction : exp_reg
    task automatic check_regs(input bit zero);
        for (int g = 0; g < 8; g++)
            for (int i = 0; i < 12; i++)
                rd_reg(SAC_ADDR_RX_CHAN_STATUS_LEFT + 16'(16 * g + i),
                       zero ? 16'h0000 : exp_reg(g, i, 1'b0), "capture");
    endtask : check_regs
    task automatic t_reset;
        rd_reg(SAC_ADDR_AUX_BLOCK_READY, 16'h0000, "ready reset");
        check(rdy, 24'h000000, "ready pin reset");
        check(bready, 24'h000001, "buffer room reset");
        rd_reg(SAC_ADDR_TX_OUTPUT_CONTROL, 16'h0000, "enable reset");
        check_regs(1'b1);
        rd_reg(16'hf61c, 16'h0000, "unmapped");
    endtask : t_reset
    task automatic t_tx;
        wr_reg(SAC_ADDR_TX_OUTPUT_CONTROL, 16'hffff);
        rd_reg(SAC_ADDR_TX_OUTPUT_CONTROL, 16'h0001, "enable read");
        check(tx_output_enable, 24'h000001, "enable pin on");
        check(aout, 24'habcdef, "audio pass");
        wr_reg(SAC_ADDR_TX_OUTPUT_CONTROL, 16'h0000);
        repeat (2) @(posedge clk);
        #1 check(aout, 24'h000000, "audio zero");
        check(tx_output_enable, 24'h000000, "enable pin off");
        check(run, 24'h000001, "stream on");
        @(posedge clk);
        pwr <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check(run, 24'h000000, "stream off");
        @(posedge clk);
        pwr <= 1'b1;
    endtask : t_tx
    task automatic t_block;
        i_src.send_block(SAC_FRAMES_PER_BLOCK, 1'b0);
        for (int n = 0; n < 50 && rdy !== 1'b1; n++) @(posedge clk);
        check(rdy, 24'h000001, "ready pin set");
        rd_reg(SAC_ADDR_AUX_BLOCK_READY, 16'h0001, "ready set");
        check_regs(1'b0);
        check(ovr, 24'h000000, "overrun");
        check(bready, 24'h000001, "buffer room");
    endtask : t_block
    task automatic t_ro;
        for (int g = 0; g < 8; g++) wr_reg(SAC_ADDR_RX_CHAN_STATUS_LEFT + 16'(16 * g + 5), 16'hffff);
        wr_reg(SAC_ADDR_AUX_BLOCK_READY, 16'h0000);
        rd_reg(SAC_ADDR_AUX_BLOCK_READY, 16'h0001, "ready kept");
        check_regs(1'b0);
    endtask : t_ro
    task automatic t_partial;
        i_src.send_block(20, 1'b1);
        check_regs(1'b0);
    endtask : t_partial
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // watchdog well beyond the two link bursts
    initial begin
        #300us;
        err_total++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_tx();
        t_block();
        t_ro();
        t_partial();
        print_verdict();
    end
endmodule : sac_top_test

// >>> src/sac_pkg.sv
/*
 * sac_pkg: constants shared by the auxiliary-bit capture block.
 * Assumes a 16-bit register port addressed by the printed word offsets.
 */
package sac_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [15:0] SAC_ADDR_AUX_BLOCK_READY      = 16'hf60f;
    localparam logic [15:0] SAC_ADDR_RX_CHAN_STATUS_LEFT  = 16'hf610;
    localparam logic [15:0] SAC_ADDR_RX_CHAN_STATUS_RIGHT = 16'hf620;
    localparam logic [15:0] SAC_ADDR_RX_USER_BITS_LEFT    = 16'hf630;
    localparam logic [15:0] SAC_ADDR_RX_USER_BITS_RIGHT   = 16'hf640;
    localparam logic [15:0] SAC_ADDR_RX_VALIDITY_LEFT     = 16'hf650;
    localparam logic [15:0] SAC_ADDR_RX_VALIDITY_RIGHT    = 16'hf660;
    localparam logic [15:0] SAC_ADDR_RX_PARITY_LEFT       = 16'hf670;
    localparam logic [15:0] SAC_ADDR_RX_PARITY_RIGHT      = 16'hf680;
    localparam logic [15:0] SAC_ADDR_TX_OUTPUT_CONTROL    = 16'hf690;
    localparam logic [15:0] SAC_GROUP_STRIDE              = 16'h0010;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int          SAC_READY_FLAG_BIT   = 0;
    localparam int          SAC_TX_ENABLE_BIT    = 0;
    localparam logic [15:0] SAC_REG_RESET        = 16'h0000;
    localparam logic        SAC_READY_RESET      = 1'b0;
    localparam logic        SAC_TX_ENABLE_RESET  = 1'b0;

    // ****************************************
    // block geometry
    // ****************************************
    localparam int SAC_FRAMES_PER_BLOCK = 192;
    localparam int SAC_REGS_PER_GROUP   = 12;
    localparam int SAC_BITS_PER_REG     = 16;
    localparam int SAC_GROUPS           = 8;  // cs, ud, vb, pb; left then right
    localparam int SAC_AUDIO_WIDTH      = 24;
    localparam int SAC_BUF_DEPTH        = 2;
    localparam int SAC_ENTRY_WIDTH      = 6;  // left, block start, cs, ud, vb, pb
    localparam logic [7:0] SAC_LAST_FRAME = 8'hbf;

endpackage : sac_pkg

// >>> src/sac_top.sv
/*
 * sac_top: captures per-subframe auxiliary bits of an incoming S/PDIF
 * stream into 192-frame register blocks, and holds the transmitter enable.
 * Assumes the link side presents one subframe's decoded auxiliary bits,
 * stable at the rising edge of link_clk_i, and that tx_audio_i and
 * tx_power_on_i come from logic on clk_sys_i.
 */
// The address-and-strobe port is this design's own decision.
// What this block does
// - take cs, user, validity, parity bits per frame, collecting 192 frames
// - after all 192 frames are decoded, the ready flag goes from 0 to 1
// - ready flag is read-only and resets to 0 (no block available)
// - channel status bits held in twelve 16-bit registers per side
// - user data bits held in twelve 16-bit registers per side
// - validity bits held in twelve 16-bit registers per side
// - parity bits held in twelve 16-bit registers per side
// - each group sits at consecutive word addresses, resetting to zero
// - captured registers are read-only; writes leave them unchanged
// - transmitter enable is bit 0, resets to 0, upper bits reserved
// - disabled transmitter keeps streaming with all-zero audio data
// - disabling does not unpower; only the power bit powers it down
module sac_top
    import sac_pkg::*;
(
    input  wire logic                       clk_sys_i,
    input  wire logic                       srst_i,
    // register port
    input  wire logic [15:0]                reg_addr_i,
    input  wire logic [15:0]                reg_wdata_i,
    input  wire logic                       reg_wr_i,
    input  wire logic                       reg_rd_i,
    output logic      [15:0]                reg_rdata_o,
    // incoming subframe auxiliary bits, on the link clock
    input  wire logic                       link_clk_i,
    input  wire logic                       link_left_i,
    input  wire logic                       link_blk_start_i,
    input  wire logic                       link_cs_i,
    input  wire logic                       link_ud_i,
    input  wire logic                       link_vb_i,
    input  wire logic                       link_pb_i,
    output logic                            link_buf_ready_o,
    output logic                            link_overrun_o,
    // transmitter side
    input  wire logic [SAC_AUDIO_WIDTH-1:0] tx_audio_i,
    input  wire logic                       tx_power_on_i,
    output logic [SAC_AUDIO_WIDTH-1:0]      tx_audio_o,
    output logic                            tx_output_enable_o,
    output logic                            tx_stream_run_o,
    output logic                            aux_block_ready_flag_o
);

    // ****************************************
    // link input synchronisers
    // ****************************************
    localparam int NSYNC = SAC_ENTRY_WIDTH + 1;

    logic [NSYNC-1:0] sync_meta;
    logic [NSYNC-1:0] sync_stab;
    logic             link_clk_prev;
    logic             link_edge;

    // two flops per pin; only sync_stab is looked at
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sync_meta <= '0;
            sync_stab <= '0;
        end else begin
            sync_meta <= {link_clk_i, link_left_i, link_blk_start_i,
                          link_cs_i, link_ud_i, link_vb_i, link_pb_i};
            sync_stab <= sync_meta;
        end
    end

    // rising edge of the sampled link clock marks one subframe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            link_clk_prev <= 1'b0;
        end else begin
            link_clk_prev <= sync_stab[NSYNC-1];
        end
    end

    assign link_edge = sync_stab[NSYNC-1] & ~link_clk_prev;

    // ****************************************
    // two-entry buffer
    // ****************************************
    logic [SAC_ENTRY_WIDTH-1:0] buf_mem [SAC_BUF_DEPTH];
    logic                       buf_wptr;
    logic                       buf_rptr;
    logic [1:0]                 buf_count;
    logic                       in_valid;
    logic                       in_ready;
    logic                       out_valid;
    logic                       out_ready;
    logic                       push;
    logic                       pop;
    logic [SAC_ENTRY_WIDTH-1:0] out_entry;

    assign in_valid  = link_edge;
    assign in_ready  = (buf_count != 2'd2);
    assign out_valid = (buf_count != 2'd0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_entry = buf_mem[buf_rptr];

    // storage and pointers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            buf_wptr  <= 1'b0;
            buf_rptr  <= 1'b0;
            buf_count <= 2'd0;
        end else begin
            if (push) begin
                buf_mem[buf_wptr] <= sync_stab[SAC_ENTRY_WIDTH-1:0];
                buf_wptr          <= ~buf_wptr;
            end
            if (pop) begin
                buf_rptr <= ~buf_rptr;
            end
            buf_count <= buf_count + {1'b0, push} - {1'b0, pop};
        end
    end

    // sticky overrun: a subframe arrived while both entries were full
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            link_overrun_o <= 1'b0;
        end else if (in_valid && !in_ready) begin
            link_overrun_o <= 1'b1;
        end
    end

    assign link_buf_ready_o = in_ready;

    // ****************************************
    // frame accumulation
    // ****************************************
    logic [SAC_FRAMES_PER_BLOCK-1:0] work [SAC_GROUPS];
    logic [SAC_FRAMES_PER_BLOCK-1:0] shadow [SAC_GROUPS];
    logic [7:0]                      frame_idx;
    logic                            locked;
    logic                            commit;
    logic                            e_left;
    logic                            e_start;
    logic [3:0]                      e_bits;   // cs, ud, vb, pb
    logic [7:0]                      next_frame_idx;

    assign e_left  = out_entry[5];
    assign e_start = out_entry[4];
    assign e_bits  = out_entry[3:0];

    // drain stalls for the one cycle in which a block is committed
    assign out_ready = ~commit;

    // the block start on a left subframe restarts the frame count
    always_comb begin
        next_frame_idx = frame_idx;
        if (e_left && e_start) begin
            next_frame_idx = 8'h00;
        end
    end

    // frame counter and lock; advances after each right subframe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            frame_idx <= 8'h00;
            locked    <= 1'b0;
            commit    <= 1'b0;
        end else begin
            commit <= 1'b0;
            if (pop) begin
                if (e_left && e_start) begin
                    locked <= 1'b1;
                end
                frame_idx <= next_frame_idx;
                if (!e_left && locked) begin
                    if (frame_idx == SAC_LAST_FRAME) begin
                        frame_idx <= 8'h00;
                        commit    <= 1'b1;
                    end else begin
                        frame_idx <= frame_idx + 8'h01;
                    end
                end
            end
        end
    end

    // per-group working bits and committed copies
    genvar g;
    generate
        for (g = 0; g < SAC_GROUPS; g++) begin : g_grp
            localparam int BIT_SEL  = 3 - (g / 2);
            localparam bit IS_RIGHT = (g % 2) == 1;

            // frame n lands in bit n of the working vector
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    work[g] <= '0;
                end else if (pop && (e_left != IS_RIGHT)
                             && (locked || (e_left && e_start))) begin
                    work[g][next_frame_idx] <= e_bits[BIT_SEL];
                end
            end

            // whole block copied at once, never bit by bit
            always_ff @(posedge clk_sys_i) begin
                if (srst_i) begin
                    shadow[g] <= '0;
                end else if (commit) begin
                    shadow[g] <= work[g];
                end
            end
        end
    endgenerate

    // ready flag: set on the first completed block, not writable
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            aux_block_ready_flag_o <= SAC_READY_RESET;
        end else if (commit) begin
            aux_block_ready_flag_o <= 1'b1;
        end
    end

    // ****************************************
    // transmitter control
    // ****************************************
    logic wr_tx_ctrl;

    assign wr_tx_ctrl = reg_wr_i && (reg_addr_i == SAC_ADDR_TX_OUTPUT_CONTROL);

    // only bit 0 is stored; reserved bits read zero
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tx_output_enable_o <= SAC_TX_ENABLE_RESET;
        end else if (wr_tx_ctrl) begin
            tx_output_enable_o <= reg_wdata_i[SAC_TX_ENABLE_BIT];
        end
    end

    // stream runs while powered; disable only zeroes the audio
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tx_audio_o      <= '0;
            tx_stream_run_o <= 1'b0;
        end else begin
            tx_stream_run_o <= tx_power_on_i;
            tx_audio_o      <= tx_output_enable_o ? tx_audio_i : '0;
        end
    end

    // ****************************************
    // register read path
    // ****************************************
    logic [15:0] next_rdata;
    logic [15:0] grp_off;
    logic [3:0]  grp_sel;
    logic [3:0]  reg_idx;

    assign grp_off = reg_addr_i - SAC_ADDR_RX_CHAN_STATUS_LEFT;
    assign grp_sel = grp_off[7:4];
    assign reg_idx = grp_off[3:0];

    // captured groups decoded by stride; writes to them are ignored
    always_comb begin
        next_rdata = SAC_REG_RESET;
        if (reg_addr_i == SAC_ADDR_AUX_BLOCK_READY) begin
            next_rdata[SAC_READY_FLAG_BIT] = aux_block_ready_flag_o;
        end else if (reg_addr_i == SAC_ADDR_TX_OUTPUT_CONTROL) begin
            next_rdata[SAC_TX_ENABLE_BIT] = tx_output_enable_o;
        end else if ((reg_addr_i >= SAC_ADDR_RX_CHAN_STATUS_LEFT)
                     && (reg_addr_i < SAC_ADDR_TX_OUTPUT_CONTROL)
                     && (reg_idx < 4'(SAC_REGS_PER_GROUP))) begin
            next_rdata = shadow[grp_sel[2:0]][reg_idx*SAC_BITS_PER_REG +: SAC_BITS_PER_REG];
        end
    end

    // read data valid in the cycle after the strobe only
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule : sac_top
